// ### rtl/tdi_pkg.sv
package tdi_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int INFO_AW     = 13;
  localparam int PAR_AW      = 14;
  localparam int ALPHA_AW    = 13;
  localparam int BLK_W       = 13;
  localparam int ITER_W      = 4;
  localparam int PAR_SEQ_BIT = 13;
  localparam int APB_AW      = 12;
  localparam int APB_DW      = 32;
  localparam int MIN_LAT     = 2;
  localparam int MAX_LAT     = 6;
  localparam int MIN_WIDTH   = 3;
  localparam int MAX_WIDTH   = 8;
  localparam int ALPHA_MUL   = 8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] CTRL_OFF = 12'h000;
  localparam logic [APB_AW-1:0] CFG_OFF  = 12'h004;
  localparam logic [APB_AW-1:0] STAT_OFF = 12'h008;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ILV_BIT   = 1;
  localparam int CTRL_HALF_BIT  = 2;
  localparam int CFG_BLK_LSB    = 0;
  localparam int CFG_ITER_LSB   = 16;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_BANK_BIT  = 1;
  localparam int STAT_HALF_BIT  = 2;

  localparam logic [BLK_W-1:0]  BLK_RST  = 13'h0028;
  localparam logic [ITER_W-1:0] ITER_RST = 4'h5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ITER_W-1:0] iterations;
    logic [BLK_W-1:0]  blockSize;
  } tdi_cfg_t;

  localparam tdi_cfg_t CFG_RST = '{iterations: ITER_RST, blockSize: BLK_RST};

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ILV  = 4'b0010,
    ST_FWD  = 4'b0100,
    ST_BWD  = 4'b1000
  } tdi_state_t;

endpackage

// ### rtl/tdi_sdp_ram.sv
module tdi_sdp_ram #(
  parameter int W  = 5,
  parameter int AW = 13
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data from a register, one cycle after re
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule // tdi_sdp_ram

// ### rtl/tdi_decoder.sv
// What this block does
// - soft values are signed log-likelihoods; zero means equal odds
// - balanced code: most negative value never used
// - results return in same signed format; sign is hard decision
// - info likelihoods loaded before start, corrected values read back
// - internal a priori memory, unreachable from outside
// - alpha memory used only as decoder scratch storage
// - info and a priori memories on-chip; parity and alpha outside
// - dual banks: decoder works one bank while host uses other
// - parity address top bit selects first or second sequence
// - largest block spans 0..5116 and 8192..13308
// - likelihood width is a build parameter, 3 to 8 bits
// - alpha and parity read pipelines each 2 to 6 stages
// - build parameter 0 or 1 selects one or two info banks
// - single clock, asynchronous global reset
// - start decodes the loaded block for the set iteration count
// - interleaver load re-initialises for the given block size
// - busy high while decoding or initialising interleaver
// - half rate zeroes alternate first and second parity values
// - 14-bit parity address and read strobe out, N-bit data in
// - busy rises one cycle after an accepted start
// - dual banks swap on every accepted start
//
// Local design decisions: register access over APB and the placing of the registers.
module tdi_decoder #(
  parameter int likelihood_width    = 5,
  parameter int alpha_read_latency  = 4,
  parameter int parity_read_latency = 4,
  parameter int dual_bank_option    = 0
) (
  // system
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  // apb slave
  input  wire logic [tdi_pkg::APB_AW-1:0]           paddr,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [tdi_pkg::APB_DW-1:0]           pwdata,
  output logic      [tdi_pkg::APB_DW-1:0]           prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // information memory host port
  input  wire logic [tdi_pkg::INFO_AW-1:0]          info_mem_addr,
  input  wire logic [likelihood_width-1:0]          info_mem_wdata,
  input  wire logic                                 info_mem_write,
  input  wire logic                                 info_mem_read,
  output logic      [likelihood_width-1:0]          info_mem_rdata,
  // parity memory
  output logic      [tdi_pkg::PAR_AW-1:0]           par_mem_addr,
  output logic                                      par_mem_read,
  input  wire logic [likelihood_width-1:0]          par_mem_rdata,
  // alpha memory
  output logic      [tdi_pkg::ALPHA_AW-1:0]         alpha_mem_addr,
  output logic                                      alpha_mem_read,
  output logic                                      alpha_mem_write,
  output logic [tdi_pkg::ALPHA_MUL*(likelihood_width-1)-1:0] alpha_mem_wdata,
  input  wire logic [tdi_pkg::ALPHA_MUL*(likelihood_width-1)-1:0]
                                                    alpha_mem_rdata
);
  import tdi_pkg::*;

  localparam int N  = likelihood_width;
  localparam int AD = ALPHA_MUL * (N - 1);
  localparam int PL = parity_read_latency;
  localparam int AL = alpha_read_latency;
  localparam int NB = (dual_bank_option != 0) ? 2 : 1;
  localparam logic [N-1:0] LMAX = {1'b0, {(N-1){1'b1}}};
  localparam logic [N-1:0] LMIN = {1'b1, {(N-2){1'b0}}, 1'b1};
  localparam logic [N-1:0] LBAD = {1'b1, {(N-1){1'b0}}};

  // ----------------------------------------------------------------
  // balanced saturating add
  // ----------------------------------------------------------------
  function automatic logic [N-1:0] satAdd(input logic [N-1:0] a,
                                          input logic [N-1:0] b);
    logic signed [N:0] s;
    s = signed'({a[N-1], a}) + signed'({b[N-1], b});
    if (s > signed'({LMAX[N-1], LMAX})) begin
      satAdd = LMAX;
    end else if (s < signed'({LMIN[N-1], LMIN})) begin
      satAdd = LMIN;
    end else begin
      satAdd = s[N-1:0];
    end
  endfunction

  tdi_state_t          stateReg;
  tdi_cfg_t            cfgReg;
  logic                halfRateReg;
  logic                hostBankReg;
  logic [BLK_W-1:0]    kReg;
  logic [BLK_W-1:0]    ilvSizeReg;
  logic [ITER_W-1:0]   iterReg;
  logic [ITER_W-1:0]   iterLastReg;
  logic                halfReg;
  logic                firstPassReg;
  logic                hostRdPendReg;
  logic                hostRdBankReg;
  logic                busy;
  logic                decoding;
  logic                issueMore;
  logic                fwdIssue;
  logic                bwdIssue;
  logic                finalPass;
  logic                pEmpty;
  logic                aEmpty;
  logic                hostBankIdx;
  logic                engBankIdx;
  logic                pV   [0:PL];
  logic [BLK_W-1:0]    pIdx [0:PL];
  logic                aV   [0:AL];
  logic [BLK_W-1:0]    aIdx [0:AL];
  logic [N-1:0]        aInfo [1:AL];
  logic [N-1:0]        aPri  [1:AL];
  logic [N-1:0]        infoRd [0:NB-1];
  logic [N-1:0]        engInfoRd;
  logic [N-1:0]        priRd;
  logic [N-1:0]        parVal;
  logic [N-1:0]        parB;
  logic [N-1:0]        priIn;
  logic [N-1:0]        newPri;
  logic [N-1:0]        newInfo;
  logic                engInfoWe;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic                apbSetup;
  logic                wrEn;
  logic                mapped;
  logic                startOk;
  logic                ilvOk;
  logic                startReq;
  logic                ilvReq;
  logic [APB_DW-1:0]   rdWord;

  assign apbSetup = psel & ~penable;
  assign wrEn     = psel & penable & pwrite;
  assign mapped   = (paddr == CTRL_OFF) || (paddr == CFG_OFF) ||
                    (paddr == STAT_OFF);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign startReq = wrEn && (paddr == CTRL_OFF) && pwdata[CTRL_START_BIT];
  assign ilvReq   = wrEn && (paddr == CTRL_OFF) && pwdata[CTRL_ILV_BIT];
  // load wins over start in the same write
  assign ilvOk    = ilvReq && !busy;
  assign startOk  = startReq && !ilvReq && !busy;

  always_comb begin
    rdWord = '0;
    if (paddr == CTRL_OFF) begin
      rdWord[CTRL_HALF_BIT] = halfRateReg;
    end else if (paddr == CFG_OFF) begin
      rdWord[CFG_BLK_LSB +: BLK_W]   = cfgReg.blockSize;
      rdWord[CFG_ITER_LSB +: ITER_W] = cfgReg.iterations;
    end else if (paddr == STAT_OFF) begin
      rdWord[STAT_BUSY_BIT] = busy;
      rdWord[STAT_BANK_BIT] = hostBankReg;
      rdWord[STAT_HALF_BIT] = halfReg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (apbSetup && !pwrite) begin
      prdata <= rdWord;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgReg      <= CFG_RST;
      halfRateReg <= 1'b0;
    end else if (wrEn && (paddr == CFG_OFF)) begin
      cfgReg.blockSize  <= pwdata[CFG_BLK_LSB +: BLK_W];
      cfgReg.iterations <= pwdata[CFG_ITER_LSB +: ITER_W];
    end else if (wrEn && (paddr == CTRL_OFF)) begin
      halfRateReg <= pwdata[CTRL_HALF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // control state machine
  // ----------------------------------------------------------------
  assign busy      = ~stateReg[0];
  assign decoding  = (stateReg == ST_FWD) || (stateReg == ST_BWD);
  assign issueMore = kReg < ilvSizeReg;
  assign fwdIssue  = (stateReg == ST_FWD) && issueMore;
  assign bwdIssue  = (stateReg == ST_BWD) && issueMore;
  assign finalPass = halfReg && (iterReg == iterLastReg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg     <= ST_IDLE;
      kReg         <= '0;
      ilvSizeReg   <= '0;
      iterReg      <= '0;
      iterLastReg  <= '0;
      halfReg      <= 1'b0;
      firstPassReg <= 1'b0;
    end else begin
      case (stateReg)
        ST_IDLE: begin
          if (ilvOk) begin
            stateReg   <= ST_ILV;
            kReg       <= '0;
            ilvSizeReg <= cfgReg.blockSize;
          end else if (startOk) begin
            stateReg     <= ST_FWD;
            kReg         <= '0;
            iterReg      <= '0;
            halfReg      <= 1'b0;
            firstPassReg <= 1'b1;
            iterLastReg  <= (cfgReg.iterations == '0) ? '0 :
                            cfgReg.iterations - 1'b1;
          end
        end
        ST_ILV: begin
          if (kReg == ilvSizeReg) begin
            stateReg <= ST_IDLE;
          end else begin
            kReg <= kReg + 1'b1;
          end
        end
        ST_FWD: begin
          if (issueMore) begin
            kReg <= kReg + 1'b1;
          end else if (pEmpty) begin
            stateReg <= ST_BWD;
            kReg     <= '0;
          end
        end
        ST_BWD: begin
          if (issueMore) begin
            kReg <= kReg + 1'b1;
          end else if (aEmpty) begin
            kReg         <= '0;
            firstPassReg <= 1'b0;
            if (finalPass) begin
              stateReg <= ST_IDLE;
            end else begin
              stateReg <= ST_FWD;
              halfReg  <= ~halfReg;
              if (halfReg) begin
                iterReg <= iterReg + 1'b1;
              end
            end
          end
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bank selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hostBankReg <= 1'b0;
    end else if (startOk && (dual_bank_option != 0)) begin
      hostBankReg <= ~hostBankReg;
    end
  end

  assign hostBankIdx = (dual_bank_option != 0) ? hostBankReg : 1'b0;
  assign engBankIdx  = (dual_bank_option != 0) ? ~hostBankReg : 1'b0;

  // ----------------------------------------------------------------
  // read pipelines
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pV[0]   <= 1'b0;
      pIdx[0] <= '0;
      aV[0]   <= 1'b0;
      aIdx[0] <= '0;
    end else begin
      pV[0]   <= fwdIssue;
      pIdx[0] <= kReg;
      aV[0]   <= bwdIssue;
      aIdx[0] <= kReg;
    end
  end

  for (genvar i = 1; i <= MAX_LAT; i++) begin : g_stage
    if (i <= PL) begin : g_p
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pV[i]   <= 1'b0;
          pIdx[i] <= '0;
        end else begin
          pV[i]   <= pV[i-1];
          pIdx[i] <= pIdx[i-1];
        end
      end
    end
    if (i <= AL) begin : g_a
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          aV[i]   <= 1'b0;
          aIdx[i] <= '0;
        end else begin
          aV[i]   <= aV[i-1];
          aIdx[i] <= aIdx[i-1];
        end
      end
      if (i == 1) begin : g_cap
        always_ff @(posedge clk or negedge reset_n) begin
          if (!reset_n) begin
            aInfo[i] <= '0;
            aPri[i]  <= '0;
          end else begin
            aInfo[i] <= engInfoRd;
            aPri[i]  <= priRd;
          end
        end
      end else begin : g_dly
        always_ff @(posedge clk or negedge reset_n) begin
          if (!reset_n) begin
            aInfo[i] <= '0;
            aPri[i]  <= '0;
          end else begin
            aInfo[i] <= aInfo[i-1];
            aPri[i]  <= aPri[i-1];
          end
        end
      end
    end
  end

  always_comb begin
    pEmpty = 1'b1;
    aEmpty = 1'b1;
    for (int j = 0; j <= PL; j++) begin
      pEmpty = pEmpty & ~pV[j];
    end
    for (int j = 0; j <= AL; j++) begin
      aEmpty = aEmpty & ~aV[j];
    end
  end

  // ----------------------------------------------------------------
  // parity and alpha memory ports
  // ----------------------------------------------------------------
  // half rate: odd first-parity and even second-parity slots punctured
  assign parVal = (halfRateReg && (halfReg ? ~pIdx[PL][0] : pIdx[PL][0]))
                  ? '0 : par_mem_rdata;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      par_mem_read <= 1'b0;
      par_mem_addr <= '0;
    end else begin
      par_mem_read <= fwdIssue;
      if (fwdIssue) begin
        par_mem_addr <= {halfReg, kReg};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alpha_mem_read  <= 1'b0;
      alpha_mem_write <= 1'b0;
      alpha_mem_addr  <= '0;
      alpha_mem_wdata <= '0;
    end else begin
      alpha_mem_read  <= bwdIssue;
      alpha_mem_write <= pV[PL];
      if (bwdIssue) begin
        alpha_mem_addr <= kReg;
      end else if (pV[PL]) begin
        alpha_mem_addr  <= pIdx[PL];
        alpha_mem_wdata <= {{(AD-N){parVal[N-1]}}, parVal};
      end
    end
  end

  // ----------------------------------------------------------------
  // update and on-chip memories
  // ----------------------------------------------------------------
  assign parB      = alpha_mem_rdata[N-1:0];
  assign priIn     = firstPassReg ? '0 : aPri[AL];
  assign newPri    = satAdd(priIn, parB);
  assign newInfo   = satAdd(aInfo[AL], newPri);
  assign engInfoWe = aV[AL] && finalPass;
  assign engInfoRd = infoRd[engBankIdx];

  tdi_sdp_ram #(.W(N), .AW(INFO_AW)) u_prior (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (aV[AL]),
    .waddr   (aIdx[AL]),
    .wdata   (newPri),
    .re      (bwdIssue),
    .raddr   (kReg),
    .rdata   (priRd)
  );

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic engOwn;
    logic bankSel;
    assign bankSel = 1'(b);
    assign engOwn  = decoding && (engBankIdx == bankSel);
    tdi_sdp_ram #(.W(N), .AW(INFO_AW)) u_info (
      .clk     (clk),
      .reset_n (reset_n),
      .we      (engOwn ? engInfoWe :
                info_mem_write && (hostBankIdx == bankSel)),
      .waddr   (engOwn ? aIdx[AL] : info_mem_addr),
      .wdata   (engOwn ? newInfo : info_mem_wdata),
      .re      (engOwn ? bwdIssue :
                info_mem_read && (hostBankIdx == bankSel)),
      .raddr   (engOwn ? kReg : info_mem_addr),
      .rdata   (infoRd[b])
    );
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hostRdPendReg  <= 1'b0;
      hostRdBankReg  <= 1'b0;
      info_mem_rdata <= '0;
    end else begin
      hostRdPendReg <= info_mem_read &&
                       !(decoding && (engBankIdx == hostBankIdx));
      hostRdBankReg <= hostBankIdx;
      if (hostRdPendReg) begin
        info_mem_rdata <= infoRd[hostRdBankReg];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  busy_rise_a: assert property (startOk |=> busy && decoding)
    else $error("busy did not rise after start");
  start_ignored_a: assert property (
    (startReq && busy) |=> $stable(hostBankReg) &&
                           !(stateReg == ST_FWD && !$past(decoding)))
    else $error("start while busy changed state");
  bank_swap_a: assert property (
    (startOk && dual_bank_option != 0) |=> hostBankReg != $past(hostBankReg))
    else $error("banks not swapped on start");
  par_span_a: assert property (
    par_mem_read |-> par_mem_addr[PAR_SEQ_BIT-1:0] < ilvSizeReg &&
                     par_mem_addr[PAR_SEQ_BIT] == halfReg)
    else $error("parity address out of span");
  alpha_own_a: assert property (
    (alpha_mem_read || alpha_mem_write) |-> busy &&
    !(alpha_mem_read && alpha_mem_write))
    else $error("alpha memory access outside decode");
  balanced_out_a: assert property (
    aV[AL] |-> newPri != LBAD && newInfo != LBAD)
    else $error("unused most negative code produced");
  puncture_zero_a: assert property (
    (pV[PL] && halfRateReg && !halfReg && pIdx[PL][0])
    |=> alpha_mem_write && alpha_mem_wdata == '0)
    else $error("punctured parity not zero");
  ilv_busy_a: assert property (
    (ilvOk && cfgReg.blockSize == 13'h0002) |=> busy [*3] ##1 !busy)
    else $error("interleaver load busy window wrong");

endmodule // tdi_decoder

// ### verif/tdi_mem_model.sv
module tdi_mem_model #(
  parameter int likelihood_width    = 5,
  parameter int alpha_read_latency  = 4,
  parameter int parity_read_latency = 4
) (
  // system
  input  wire logic                             clk,
  // parity memory
  input  wire logic [tdi_pkg::PAR_AW-1:0]       parAddr,
  input  wire logic                             parRead,
  output logic      [likelihood_width-1:0]      parRdata,
  // alpha memory
  input  wire logic [tdi_pkg::ALPHA_AW-1:0]     alphaAddr,
  input  wire logic                             alphaRead,
  input  wire logic                             alphaWrite,
  input  wire logic [tdi_pkg::ALPHA_MUL*(likelihood_width-1)-1:0] alphaWdata,
  output logic [tdi_pkg::ALPHA_MUL*(likelihood_width-1)-1:0] alphaRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import tdi_pkg::*;
  localparam int N   = likelihood_width;
  localparam int PL  = parity_read_latency;
  localparam int AL  = alpha_read_latency;
  localparam int AWD = ALPHA_MUL*(N-1);
  // two separate storages, no shared port
  // one parity bank: the bench builds the single info bank option
  logic [N-1:0]   parMem   [0:16383];
  logic [AWD-1:0] alphaMem [0:8191];
  logic [N-1:0]   parPipe  [PL];
  logic [AWD-1:0] alphaPipe [AL];
  logic [PL-1:0]  parVld = '0;
  logic [AL-1:0]  alphaVld = '0;

  // one access per cycle, pipelined reads
  always @(posedge clk) begin
    parPipe[0] <= parMem[parAddr];
    alphaPipe[0] <= alphaMem[alphaAddr];
    for (int i = 1; i < PL; i++) parPipe[i] <= parPipe[i-1];
    for (int i = 1; i < AL; i++) alphaPipe[i] <= alphaPipe[i-1];
    parVld <= {parVld[PL-2:0], parRead};
    alphaVld <= {alphaVld[AL-2:0], alphaRead};
    if (alphaWrite) alphaMem[alphaAddr] <= alphaWdata;
  end

  // outside the valid slot the bus shows garbage
  assign parRdata = parVld[PL-1] ? parPipe[PL-1] : ~parPipe[PL-1];
  assign alphaRdata = alphaVld[AL-1] ? alphaPipe[AL-1] : ~alphaPipe[AL-1];
endmodule // tdi_mem_model

// ### verif/turbo_decoder_interfaces_tb.sv
module turbo_decoder_interfaces_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tdi_pkg::*;
  localparam int N   = 5;
  localparam int AWD = ALPHA_MUL*(N-1);
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, infoWrite = 0, infoRead = 0;
  logic [INFO_AW-1:0] infoAddr = '0;
  logic [N-1:0] infoWdata = '0, infoRdata, parRdata;
  logic parRead, alphaRead, alphaWrite;
  logic [PAR_AW-1:0] parAddr;
  logic [ALPHA_AW-1:0] alphaAddr;
  logic [AWD-1:0] alphaWdata, alphaRdata;
  int failures = 0, cmp_count = 0, cycles = 0;
  int seq0 = 0, seq1 = 0, bad = 0;

  always #25 clk = ~clk;

  tdi_decoder i_tdi_decoder (.clk(clk), .reset_n(reset_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .info_mem_addr(infoAddr), .info_mem_wdata(infoWdata),
    .info_mem_write(infoWrite), .info_mem_read(infoRead),
    .info_mem_rdata(infoRdata), .par_mem_addr(parAddr),
    .par_mem_read(parRead), .par_mem_rdata(parRdata),
    .alpha_mem_addr(alphaAddr), .alpha_mem_read(alphaRead),
    .alpha_mem_write(alphaWrite), .alpha_mem_wdata(alphaWdata),
    .alpha_mem_rdata(alphaRdata));
  tdi_mem_model i_tdi_mem_model (.clk(clk), .parAddr(parAddr),
    .parRead(parRead), .parRdata(parRdata), .alphaAddr(alphaAddr),
    .alphaRead(alphaRead), .alphaWrite(alphaWrite),
    .alphaWdata(alphaWdata), .alphaRdata(alphaRdata));

  always @(posedge clk) begin
    cycles++;
    if (parRead === 1'b1) begin
      if (parAddr[PAR_SEQ_BIT]) seq1++;
      else seq0++;
      if (parAddr[12:0] >= 13'h0008) bad++;
    end
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic info(input logic w, input int a, input logic [N-1:0] d);
    @(posedge clk);
    infoAddr <= 13'(a); infoWdata <= d; infoWrite <= w; infoRead <= !w;
    @(posedge clk);
    infoWrite <= 0; infoRead <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(0, STAT_OFF, 0);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    chk("busy clears", 0, 32'(rd[STAT_BUSY_BIT]));
  endtask

  task automatic t_reset;
    apb(0, CFG_OFF, 0);
    chk("cfg reset", {12'h0, ITER_RST, 3'h0, BLK_RST}, rd);
    apb(0, STAT_OFF, 0);
    chk("status reset", 0, rd);
    apb(0, 12'h00c, 0);
    chk("unmapped error", 1, 32'(err));
    chk("unmapped data", 0, rd);
    chk("ready tied high", 1, 32'(pready));
  endtask

  task automatic t_load;
    apb(1, CFG_OFF, 32'h0001_0002);
    apb(1, CTRL_OFF, 32'h2);
    wait_idle();
    apb(1, CFG_OFF, 32'h0001_0008);
    apb(1, CTRL_OFF, 32'h2);
    @(posedge clk);
    apb(0, STAT_OFF, 0);
    chk("busy in load", 1, 32'(rd[STAT_BUSY_BIT]));
    apb(1, CTRL_OFF, 32'h1);
    wait_idle();
    repeat (5) @(posedge clk);
    apb(0, STAT_OFF, 0);
    chk("start dropped", 0, 32'(rd[STAT_BUSY_BIT]));
    chk("no parity reads", 0, 32'(seq0 + seq1));
  endtask

  task automatic t_info;
    logic [N-1:0] v [4] = '{5'h0f, 5'h11, 5'h00, 5'h01};
    for (int i = 0; i < 4; i++) info(1, i, v[i]);
    for (int i = 0; i < 4; i++) begin
      info(0, i, 0);
      chk("info readback", 32'(v[i]), 32'(infoRdata));
    end
  endtask

  task automatic t_half;
    apb(1, CTRL_OFF, 32'h4);
    apb(0, CTRL_OFF, 0);
    chk("half rate flag", 1, 32'(rd[CTRL_HALF_BIT]));
    apb(1, CTRL_OFF, 32'h0);
  endtask

  task automatic t_decode;
    for (int i = 0; i < 8; i++) begin
      info(1, i, 5'h0f);
      i_tdi_mem_model.parMem[i] = 5'h0f;
      i_tdi_mem_model.parMem[8192+i] = 5'h0f;
    end
    apb(1, CTRL_OFF, 32'h5);
    @(posedge clk);
    apb(0, STAT_OFF, 0);
    chk("busy in decode", 1, 32'(rd[STAT_BUSY_BIT]));
    apb(1, CTRL_OFF, 32'h6);
    wait_idle();
    chk("first seq reads", 8, 32'(seq0));
    chk("second seq reads", 8, 32'(seq1));
    chk("parity range", 0, 32'(bad));
    for (int i = 0; i < 8; i++) begin
      info(0, i, 0);
      chk("hard decision", 0, 32'(infoRdata[N-1]));
      chk("balanced code", 1, 32'(infoRdata !== 5'h10));
      chk("decoded value", 32'h0000_000f, 32'(infoRdata));
      chk("alpha parity", (i % 2) ? 32'h0000_000f : 32'h0,
          i_tdi_mem_model.alphaMem[i]);
    end
  endtask

  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1;
    t_reset();
    t_load();
    t_info();
    t_half();
    t_decode();
    end_of_test();
  end
endmodule // turbo_decoder_interfaces_tb
